// >>> logic/asp_dev.sv
// asp_dev: converter end of the serial output port
// assumes: i_mclk is the master clock; straps are static levels from board logic
// What this block does
// - serial clock full or half master rate
// - rate select picks decimate 16 or 32
// - filter select: high low-pass, low band-pass
// - drive data only when enable equals slot level
// - unshared line: hold slot and enable low
// - frame sync marks each word start, except back-to-back frames in modes 2 and 3 with format high, which hold it low
// - mode 1 format low: one-cycle high pulse
// - mode 1 format high: low over 16 bits
// - word shifted msb first on serial clock
// - mode 1: 16 bits then 16 zeros
// - modes 2 and 3: 16 cycles per word
// - modes 2 and 3 need format held high
// - frame sync input realigns output register
// - board may tie frame sync to enable
// - clock format strap unused; data always changes on serial clock rise
`timescale 1ns/1ps
module asp_dev
	import asp_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_rstn,
	input  wire logic [1:0]  i_serial_mode,
	input  wire logic        i_serial_clock_rate_sel,
	input  wire logic        i_output_rate_sel,
	input  wire logic        i_filter_shape_sel,
	input  wire logic        i_time_slot_polarity,
	input  wire logic        i_output_enable_in,
	input  wire logic        i_frame_format_sel,
	input  wire logic        i_clock_edge_format,
	input  wire logic [15:0] i_sample,
	output logic             o_sample_take,
	output logic [15:0]      o_filtered,
	asp_link_if.dev          link
);
	logic        div_r;
	logic        sck_en;
	logic        fsi_s;
	logic        fsi_d_r;
	logic        fsi_rise;
	logic        oe_s;
	logic        tsi_s;
	logic [5:0]  dec_cnt_r;
	logic [5:0]  dec_len;
	logic [5:0]  bit_cnt_r;
	logic [5:0]  frame_len;
	logic [15:0] word_r;
	logic [15:0] shift_r;
	logic [15:0] filt_prev_r;
	logic [15:0] filt_r;
	logic        pend_r;
	logic        active_r;
	logic        sdo_r;
	logic        fso_r;
	logic        sco_r;
	logic        start_now;

	////////////////////////////////////////////////////////////////
	// pin synchronisers
	asp_sync2 u_fsi (.i_clk(i_mclk), .i_rstn(i_rstn), .i_d(link.frame_sync_in), .o_q(fsi_s));
	asp_sync2 u_oe  (.i_clk(i_mclk), .i_rstn(i_rstn), .i_d(i_output_enable_in), .o_q(oe_s));
	asp_sync2 u_tsi (.i_clk(i_mclk), .i_rstn(i_rstn), .i_d(i_time_slot_polarity), .o_q(tsi_s));

	////////////////////////////////////////////////////////////////
	// serial clock rate divider
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
			div_r <= 1'b0;
		else
			div_r <= ~div_r;
	end
	assign sck_en = ~i_serial_clock_rate_sel | div_r;

	// serial clock out: half rate follows div_r via register; full rate is mclk itself
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
			sco_r <= 1'b0;
		else if (i_serial_clock_rate_sel)
			sco_r <= div_r; // half rate: rises with data, falls mid-bit
		else
			sco_r <= 1'b1;
	end
	// full rate uses master clock itself gated by strap
	assign link.serial_clock_out = i_serial_clock_rate_sel ? sco_r : i_mclk;

	////////////////////////////////////////////////////////////////
	// frame sync input edge detect on synchronised level
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
			fsi_d_r <= 1'b0;
		else
			fsi_d_r <= fsi_s;
	end
	assign fsi_rise = fsi_s & ~fsi_d_r;

	////////////////////////////////////////////////////////////////
	// decimation counter; frame sync input restarts it
	assign dec_len = i_output_rate_sel ? ASP_DEC_SLOW : ASP_DEC_FAST;
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
			dec_cnt_r <= 6'h00;
		else if (fsi_rise)
			dec_cnt_r <= 6'h00;
		else if (dec_cnt_r == dec_len - 6'h01)
			dec_cnt_r <= 6'h00;
		else
			dec_cnt_r <= dec_cnt_r + 6'h01;
	end
	assign o_sample_take = (dec_cnt_r == dec_len - 6'h01) & ~fsi_rise;

	////////////////////////////////////////////////////////////////
	// filter stage: low-pass average or band-pass difference
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			filt_prev_r <= ASP_SAMPLE_RESET;
			filt_r      <= ASP_SAMPLE_RESET;
		end
		else if (o_sample_take)
		begin
			filt_prev_r <= i_sample;
			if (i_filter_shape_sel)
				filt_r <= 16'((17'(signed'(i_sample)) + 17'(signed'(filt_prev_r))) >>> 1);
			else
				filt_r <= 16'((17'(signed'(i_sample)) - 17'(signed'(filt_prev_r))) >>> 1);
		end
	end
	assign o_filtered = filt_r;

	////////////////////////////////////////////////////////////////
	// output data register, updated on each decimated word
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			word_r <= ASP_SAMPLE_RESET;
			pend_r <= 1'b0;
		end
		else if (o_sample_take)
		begin
			word_r <= filt_r;
			pend_r <= 1'b1;
		end
		else if (start_now)
			pend_r <= 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// frame length per serial mode
	assign frame_len = (i_serial_mode == ASP_MODE1) ? ASP_M1_CYCLES : ASP_M23_CYCLES;
	// a new frame starts from idle or straight after the last slot, so frames can run back to back
	assign start_now = sck_en & pend_r & (~active_r | (bit_cnt_r == frame_len));

	// shifter, counted in serial clock cycles
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			active_r  <= 1'b0;
			bit_cnt_r <= 6'h00;
			shift_r   <= ASP_SAMPLE_RESET;
			sdo_r     <= 1'b0;
		end
		else if (sck_en)
		begin
			if (start_now)
			begin
				active_r  <= 1'b1;
				bit_cnt_r <= 6'h01;
				sdo_r     <= word_r[15];
				shift_r   <= {word_r[14:0], 1'b0};
			end
			else if (active_r)
			begin
				sdo_r   <= shift_r[15]; // zeros after lsb
				shift_r <= {shift_r[14:0], 1'b0};
				if (bit_cnt_r == frame_len)
				begin
					active_r  <= 1'b0;
					bit_cnt_r <= 6'h00;
					sdo_r     <= 1'b0;
				end
				else
					bit_cnt_r <= bit_cnt_r + 6'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// frame sync output format
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
			fso_r <= 1'b1;
		else if (sck_en)
		begin
			if (start_now)
				fso_r <= ~i_frame_format_sel;
			else if (!i_frame_format_sel)
				fso_r <= 1'b0;
			else if (active_r && bit_cnt_r < 6'(ASP_WORD_W))
				fso_r <= 1'b0;
			else
				fso_r <= 1'b1;
		end
	end
	assign link.frame_sync_out = i_frame_format_sel ? fso_r : (fso_r & active_r);

	////////////////////////////////////////////////////////////////
	// data line drive; clock format only tells the receiver its edge
	assign link.serial_data_out = sdo_r;
	assign link.serial_data_oe  = (oe_s == tsi_s);
	// data changes on mclk rise; stable across the chosen sample edge
	logic unused_clock_edge_format;
	assign unused_clock_edge_format = i_clock_edge_format;
endmodule : asp_dev

// >>> logic/asp_link_if.sv
// asp_link_if: serial port wires between converter and receiver
// assumes: the bench resolves the data line from its enable
`timescale 1ns/1ps
interface asp_link_if;
	logic serial_clock_out;
	logic serial_data_out;
	logic serial_data_oe;
	logic frame_sync_out;
	logic frame_sync_in;
	modport dev
	(
		output serial_clock_out,
		output serial_data_out,
		output serial_data_oe,
		output frame_sync_out,
		input  frame_sync_in
	);
	modport rcv
	(
		input  serial_clock_out,
		input  serial_data_out,
		input  serial_data_oe,
		input  frame_sync_out,
		output frame_sync_in
	);
endinterface : asp_link_if

// >>> logic/asp_pkg.sv
// asp_pkg: constants shared by both ends of the converter serial port
// assumes: nothing beyond a SystemVerilog tool
package asp_pkg;
	localparam int          ASP_WORD_W       = 16;
	localparam logic [5:0]  ASP_M1_CYCLES    = 6'h20; // mode 1 frame length
	localparam logic [5:0]  ASP_M23_CYCLES   = 6'h10; // modes 2/3 frame length
	localparam logic [5:0]  ASP_DEC_FAST     = 6'h10; // decimate by 16
	localparam logic [5:0]  ASP_DEC_SLOW     = 6'h20; // decimate by 32
	localparam logic [15:0] ASP_SAMPLE_RESET = 16'h0000;
	localparam logic [15:0] ASP_MIDSCALE     = 16'h8000;
	localparam logic [1:0]  ASP_MODE1        = 2'h1;
	localparam logic [1:0]  ASP_MODE2        = 2'h2;
	localparam logic [1:0]  ASP_MODE3        = 2'h3;
	typedef enum logic [1:0] {ASP_RX_IDLE, ASP_RX_SHIFT, ASP_RX_DONE} asp_rx_state_t;
endpackage : asp_pkg

// >>> logic/asp_rcv.sv
// asp_rcv: receiver end, samples the serial port on the link clock
// assumes: link clock is the converter serial clock output
`timescale 1ns/1ps
module asp_rcv
	import asp_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_rstn,
	input  wire logic        i_sync_req,
	input  wire logic        i_frame_format_sel,
	output logic [15:0]      o_word,
	output logic             o_word_valid,
	asp_link_if.rcv          link
);
	logic          sck;
	logic          lrst_s;
	logic          lrst_m_r;
	logic [15:0]   sh_r;
	logic [4:0]    cnt_r;
	logic [15:0]   hold_r;
	logic          tog_r;
	logic          tog_s;
	logic          tog_d_r;
	logic          fs_d_r;
	logic          fs_start;
	logic          wrap_r;
	asp_rx_state_t st_r;

	assign sck = link.serial_clock_out;
	assign link.frame_sync_in = i_sync_req;

	////////////////////////////////////////////////////////////////
	// reset release in link domain
	always_ff @(posedge sck or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			lrst_m_r <= 1'b0;
			lrst_s   <= 1'b0;
		end
		else
		begin
			lrst_m_r <= 1'b1;
			lrst_s   <= lrst_m_r;
		end
	end

	// start of word per frame format
	// back to back frames in modes 2 and 3 keep sync low, so a word end with sync still low starts the next
	assign fs_start = i_frame_format_sel ? ((fs_d_r | wrap_r) & ~link.frame_sync_out) : link.frame_sync_out;

	////////////////////////////////////////////////////////////////
	// shift in msb first on the falling edge
	always_ff @(negedge sck or negedge lrst_s)
	begin
		if (!lrst_s)
		begin
			st_r   <= ASP_RX_IDLE;
			sh_r   <= ASP_SAMPLE_RESET;
			cnt_r  <= 5'h00;
			hold_r <= ASP_SAMPLE_RESET;
			tog_r  <= 1'b0;
			fs_d_r <= 1'b1;
			wrap_r <= 1'b0;
		end
		else
		begin
			fs_d_r <= link.frame_sync_out;
			wrap_r <= 1'b0;
			case (st_r)
				ASP_RX_IDLE:
				begin
					if (fs_start && link.serial_data_oe)
					begin
						sh_r  <= {15'h0000, link.serial_data_out};
						cnt_r <= 5'h01;
						st_r  <= ASP_RX_SHIFT;
					end
				end
				ASP_RX_SHIFT:
				begin
					sh_r  <= {sh_r[14:0], link.serial_data_out};
					cnt_r <= cnt_r + 5'h01;
					if (cnt_r == 5'(ASP_WORD_W - 1))
					begin
						hold_r <= {sh_r[14:0], link.serial_data_out};
						tog_r  <= ~tog_r;
						wrap_r <= 1'b1;
						st_r   <= ASP_RX_IDLE;
					end
				end
				ASP_RX_DONE:
				begin
					hold_r <= sh_r;
					tog_r  <= ~tog_r;
					st_r   <= ASP_RX_IDLE;
				end
				default:
					st_r <= ASP_RX_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// word handoff to mclk by toggle
	asp_sync2 u_tog (.i_clk(i_mclk), .i_rstn(i_rstn), .i_d(tog_r), .o_q(tog_s));
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			tog_d_r      <= 1'b0;
			o_word       <= ASP_SAMPLE_RESET;
			o_word_valid <= 1'b0;
		end
		else
		begin
			tog_d_r      <= tog_s;
			o_word_valid <= tog_s ^ tog_d_r;
			if (tog_s ^ tog_d_r)
				o_word <= hold_r;
		end
	end
endmodule : asp_rcv

// >>> logic/asp_sync2.sv
// asp_sync2: two-flop level synchroniser
// assumes: destination clock and active-low async reset
`timescale 1ns/1ps
module asp_sync2
(
	input  wire logic i_clk,
	input  wire logic i_rstn,
	input  wire logic i_d,
	output logic      o_q
);
	logic meta_r;
	////////////////////////////////////////////////////////////////
	// first flop feeds only the second
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			meta_r <= 1'b0;
			o_q    <= 1'b0;
		end
		else
		begin
			meta_r <= i_d;
			o_q    <= meta_r;
		end
	end
endmodule : asp_sync2

// >>> sim/asp_link_chk.sv
// asp_link_chk: assertions on the serial port wires
// assumes: straps change only while reset is low
`timescale 1ns/1ps
module asp_link_chk
	import asp_pkg::*;
(
	input  wire logic       i_mclk,
	input  wire logic       i_rstn,
	input  wire logic [1:0] i_serial_mode,
	input  wire logic       i_serial_clock_rate_sel,
	input  wire logic       i_time_slot_polarity,
	input  wire logic       i_output_enable_in,
	input  wire logic       i_frame_format_sel,
	input  wire logic       serial_clock_out,
	input  wire logic       serial_data_out,
	input  wire logic       serial_data_oe,
	input  wire logic       frame_sync_out
);
	logic [5:0] slot_r;
	logic [4:0] low_r;
	logic       fso_q_r;
	logic [2:0] run_r;
	logic       start;
	logic       m1;
	////////////////////////////////////////////////////////////////
	// word start seen on the frame sync line
	assign start = i_frame_format_sel ? (fso_q_r & ~frame_sync_out) : (~fso_q_r & frame_sync_out);
	assign m1    = (i_serial_mode == ASP_MODE1);
	// slot count from start, low run length, previous sync level
	always_ff @(negedge serial_clock_out or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			slot_r  <= 6'h3F;
			low_r   <= 5'h00;
			fso_q_r <= 1'b1;
		end
		else
		begin
			slot_r  <= start ? 6'h01 : (slot_r == 6'h3F ? slot_r : slot_r + 6'h01);
			low_r   <= frame_sync_out ? 5'h00 : (low_r == 5'h1F ? low_r : low_r + 5'h01);
			fso_q_r <= frame_sync_out;
		end
	end
	// settle counter after reset release
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
			run_r <= 3'h0;
		else if (run_r != 3'h7)
			run_r <= run_r + 3'h1;
	end
	////////////////////////////////////////////////////////////////
	a_pulse_one_cycle: assert property (@(negedge serial_clock_out) disable iff (!i_rstn)
		(m1 && !i_frame_format_sel && start) |=> !frame_sync_out) else $error("sync pulse too wide");
	a_frame_low_span: assert property (@(negedge serial_clock_out) disable iff (!i_rstn)
		(i_frame_format_sel && frame_sync_out && !fso_q_r) |-> low_r == 5'h10) else $error("frame low span");
	a_tail_zeros: assert property (@(negedge serial_clock_out) disable iff (!i_rstn)
		(m1 && !start && slot_r >= 6'h10 && slot_r <= 6'h1F && serial_data_oe) |-> !serial_data_out)
		else $error("tail not zero");
	a_tail_sync_high: assert property (@(negedge serial_clock_out) disable iff (!i_rstn)
		(m1 && i_frame_format_sel && !start && slot_r >= 6'h10 && slot_r <= 6'h1F) |-> frame_sync_out)
		else $error("sync low in tail");
	a_frame_spacing: assert property (@(negedge serial_clock_out) disable iff (!i_rstn)
		start |=> (!start)[*8]) else $error("frames too close");
	a_oe_match: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		(run_r == 3'h7 && i_output_enable_in == i_time_slot_polarity)[*4] |-> serial_data_oe)
		else $error("data not driven");
	a_oe_block: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		(run_r == 3'h7 && i_output_enable_in != i_time_slot_polarity)[*4] |-> !serial_data_oe)
		else $error("data driven");
	a_half_rate: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		(run_r == 3'h7 && i_serial_clock_rate_sel)[*2] |-> serial_clock_out != $past(serial_clock_out))
		else $error("half rate clock stalled");
	c_pulse: cover property (@(negedge serial_clock_out) disable iff (!i_rstn) m1 && !i_frame_format_sel && start);
	c_frame: cover property (@(negedge serial_clock_out) disable iff (!i_rstn) m1 && i_frame_format_sel && start);
	c_short: cover property (@(negedge serial_clock_out) disable iff (!i_rstn) !m1 && start);
endmodule : asp_link_chk

// >>> sim/asp_tb_top.sv
// asp_tb_top: converter end and receiver end joined by the link
// assumes: straps are set under reset; receiver words are checked
`timescale 1ns/1ps
module asp_tb_top
	import asp_pkg::*;
;
	logic i_mclk = 1'h0;
	logic i_rstn = 1'h0;
	logic [1:0] i_serial_mode = ASP_MODE1;
	logic sr = 1'h0, dr = 1'h1, lp = 1'h1, ts = 1'h0, en = 1'h0, ff = 1'h1, i_sync_req = 1'h0;
	logic [15:0] i_sample = 16'h0000;
	logic [15:0] o_word;
	logic o_word_valid;
	int mismatches = 0;
	int n_compared = 0;
	asp_link_if link ();
	asp_dev asp_dev_i (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_serial_mode(i_serial_mode),
		.i_serial_clock_rate_sel(sr), .i_output_rate_sel(dr), .i_filter_shape_sel(lp),
		.i_time_slot_polarity(ts), .i_output_enable_in(en), .i_frame_format_sel(ff),
		.i_clock_edge_format(1'h0), .i_sample(i_sample), .o_sample_take(), .o_filtered(), .link(link));
	asp_rcv asp_rcv_i (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_sync_req(i_sync_req), .i_frame_format_sel(ff),
		.o_word(o_word), .o_word_valid(o_word_valid), .link(link));
	asp_link_chk asp_link_chk_i (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_serial_mode(i_serial_mode),
		.i_serial_clock_rate_sel(sr), .i_time_slot_polarity(ts), .i_output_enable_in(en),
		.i_frame_format_sel(ff), .serial_clock_out(link.serial_clock_out),
		.serial_data_out(link.serial_data_out), .serial_data_oe(link.serial_data_oe),
		.frame_sync_out(link.frame_sync_out));
	////////////////////////////////////////////////////////////////
	// master clock
	always #10 i_mclk = ~i_mclk;
	// compare and count
	task chk(input logic [15:0] s, input logic [15:0] e);
		n_compared++;
		if (s !== e)
		begin
			mismatches++;
			$display("Error t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	// verdict and end of run
	task summarize;
		$display("compared=%0d mismatches=%0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize
	// straps under reset, then three words and their spacing
	task run(input logic [1:0] m, input logic [6:0] st, input logic [15:0] s, input logic [15:0] e,
		input logic w);
		int k;
		int got;
		int t0;
		int sp;
		@(negedge i_mclk);
		i_rstn = 1'h0;
		{i_serial_mode, sr, dr, lp, ff, ts, en, i_sample} = {m, st[6:1], s};
		repeat (6) @(negedge i_mclk);
		i_rstn = 1'h1;
		got = 0;
		t0 = 0;
		sp = 0;
		for (k = 0; k < 600 && got < 3; k++)
		begin
			@(negedge i_mclk);
			i_sync_req = st[0] && (k == 5);
			if (o_word_valid === 1'h1)
			begin
				got++;
				if (got == 1)
					t0 = k;
				sp = k - t0;
			end
		end
		i_sync_req = 1'h0;
		chk(16'(got), w ? 16'h0003 : 16'h0000);
		if (w)
		begin
			chk(o_word, e);
			chk(16'(sp), dr ? 16'h0040 : 16'h0020);
		end
	endtask : run
	////////////////////////////////////////////////////////////////
	// straps: rate, dec, lowpass, format, slot, enable, sync
	initial
	begin
		run(ASP_MODE1, 7'b0111000, 16'hA5C3, 16'hA5C3, 1'h1);
		run(ASP_MODE1, 7'b0110000, 16'h8001, 16'h8001, 1'h1);
		run(ASP_MODE2, 7'b1111000, 16'h7FFE, 16'h7FFE, 1'h1);
		run(ASP_MODE3, 7'b0111001, 16'h0F0F, 16'h0F0F, 1'h1);
		run(ASP_MODE2, 7'b0011000, 16'h1234, 16'h1234, 1'h1);
		run(ASP_MODE1, 7'b0101000, 16'h4321, 16'h0000, 1'h1);
		run(ASP_MODE1, 7'b0111100, 16'h5555, 16'h0000, 1'h0);
		run(ASP_MODE1, 7'b0111110, 16'hC0DE, 16'hC0DE, 1'h1);
		summarize();
	end
	// watchdog against a hang
	initial
	begin
		#300000;
		mismatches++;
		summarize();
	end
endmodule : asp_tb_top
